// >>> battery_voltage_monitor_tb.sv
// Purpose: self-checking bench of the battery monitor
// Assumes: host model drives the register port
// Notes:   paired result reads go upper first; a lone lower read checks the clear flag
`include "bvm_map.svh"
`timescale 1ns/1ns
`default_nettype none
module battery_voltage_monitor_tb;
    logic                  core_clk, rst, normal_mode, under_voltage_irq, over_voltage_irq, load_shutdown;
    bvm_pkg::bvm_results_t results;
    bvm_pkg::bvm_reg_req_t reg_req;
    logic [1:0]            shutdown_ctrl;
    logic [7:0]            reg_rdata, d, c;
    logic [9:0]            v;
    int                    fails, n_checks, n_uv, n_ov;
    bvm_host host_u (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
    bvm_monitor dut_u (.core_clk(core_clk), .rst(rst), .normal_mode(normal_mode), .results(results),
        .reg_req(reg_req), .shutdown_ctrl(shutdown_ctrl), .reg_rdata(reg_rdata),
        .under_voltage_irq(under_voltage_irq), .over_voltage_irq(over_voltage_irq),
        .load_shutdown(load_shutdown));
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        if (!rst && under_voltage_irq === 1'b1) n_uv++;
        if (!rst && over_voltage_irq === 1'b1) n_ov++;
    end
    task automatic finish_test;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    function automatic logic [7:0] exp_lower(input logic f, input logic [9:0] r);
        return {5'h00, f, r[1:0]};
    endfunction
    function automatic logic [7:0] exp_stat(input logic uv, input logic ov);
        return {2'h0, ov, uv, 4'h0};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
        host_u.rd(a, d);
        chk(d, exp);
    endtask
    task automatic schk(input logic uv, input logic ov);
        rchk(`BVM_ADDR_SUPPLY_STAT, exp_stat(uv, ov));
    endtask
    task automatic drive(input logic [9:0] b, input logic [9:0] s);
        @(posedge core_clk);
        results <= {b, s};
        repeat (4) @(posedge core_clk);
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fails++;
        finish_test;
    end
    initial
    begin
        fails = 0; n_checks = 0; n_uv = 0; n_ov = 0;
        rst = 1'b1; normal_mode = 1'b0; results = '0; shutdown_ctrl = 2'h0;
        void'($urandom(77));
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rchk(`BVM_ADDR_SRC_SEL, 8'h00);
        rchk(`BVM_ADDR_OVER_TRIP, 8'hFF);
        rchk(`BVM_ADDR_HYST, 8'h00);
        rchk(7'h7F, 8'h00);
        host_u.wr(`BVM_ADDR_BAT_UPPER, 8'hA5);
        rchk(`BVM_ADDR_BAT_UPPER, 8'h00);
        rchk(`BVM_ADDR_BAT_LOWER, exp_lower(1'b1, 10'h000));
        for (int i = 0; i < 8; i++)
        begin
            c = 8'($urandom);
            v = 10'($urandom);
            host_u.wr(`BVM_ADDR_UNDER_TRIP, c);
            rchk(`BVM_ADDR_UNDER_TRIP, c);
            host_u.wr(`BVM_ADDR_OVER_TRIP, ~c);
            rchk(`BVM_ADDR_OVER_TRIP, ~c);
            host_u.wr(`BVM_ADDR_SRC_SEL, c);
            rchk(`BVM_ADDR_SRC_SEL, {7'h00, c[0]});
            drive(v, ~v);
            rchk(`BVM_ADDR_BAT_LOWER, exp_lower(1'b0, v));
            rchk(`BVM_ADDR_BAT_UPPER, v[9:2]);
            drive(~v, v);
            rchk(`BVM_ADDR_BAT_LOWER, exp_lower(1'b1, v));
            rchk(`BVM_ADDR_SNS_UPPER, v[9:2]);
            rchk(`BVM_ADDR_SNS_LOWER, exp_lower(1'b1, v));
        end
        chk(8'(n_uv + n_ov), 8'h00);
        host_u.wr(`BVM_ADDR_SRC_SEL, 8'h00);
        host_u.wr(`BVM_ADDR_UNDER_TRIP, 8'h40);
        host_u.wr(`BVM_ADDR_OVER_TRIP, 8'h80);
        host_u.wr(`BVM_ADDR_HYST, 8'h11);
        rchk(`BVM_ADDR_HYST, 8'h11);
        shutdown_ctrl <= 2'h1;
        drive(10'd300, 10'd300);
        normal_mode <= 1'b1;
        drive(10'd100, 10'd300);
        schk(1'b1, 1'b0);
        chk(8'(n_uv), 8'h01);
        chk({7'h00, load_shutdown}, 8'h01);
        drive(10'd260, 10'd300);
        schk(1'b1, 1'b0);
        drive(10'd100, 10'd300);
        chk(8'(n_uv), 8'h01);
        drive(10'd300, 10'd300);
        schk(1'b0, 1'b0);
        drive(10'd600, 10'd300);
        schk(1'b0, 1'b1);
        chk(8'(n_ov), 8'h01);
        chk({7'h00, load_shutdown}, 8'h00);
        shutdown_ctrl <= 2'h2;
        drive(10'd500, 10'd300);
        schk(1'b0, 1'b1);
        chk({7'h00, load_shutdown}, 8'h01);
        drive(10'd600, 10'd300);
        chk(8'(n_ov), 8'h01);
        drive(10'd400, 10'd300);
        schk(1'b0, 1'b0);
        host_u.wr(`BVM_ADDR_SRC_SEL, 8'h01);
        drive(10'd400, 10'd100);
        schk(1'b1, 1'b0);
        chk(8'(n_uv), 8'h02);
        normal_mode <= 1'b0;
        drive(10'd700, 10'd700);
        schk(1'b0, 1'b0);
        chk(8'(n_ov), 8'h01);
        normal_mode <= 1'b1;
        drive(10'd50, 10'd50);
        chk(8'(n_uv), 8'h03);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        schk(1'b0, 1'b0);
        rchk(`BVM_ADDR_UNDER_TRIP, 8'h00);
        rchk(`BVM_ADDR_SRC_SEL, 8'h00);
        chk(8'(n_uv), 8'h03);
        finish_test;
    end
endmodule // battery_voltage_monitor_tb
`default_nettype wire

// >>> bvm_host.sv
// Purpose: host model issuing register requests to the monitor
// Assumes: one-cycle rd/wr strobes, read data taken at the sampling edge
// Notes:   idle request fields show inverted values, never stale ones
`timescale 1ns/1ns
`default_nettype none
module bvm_host (
    input  wire logic                  core_clk,
    input  wire logic [7:0]            reg_rdata,
    output var bvm_pkg::bvm_reg_req_t  reg_req
);
    initial reg_req = '0;
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= {1'b0, 1'b1, a, d};
        @(posedge core_clk);
        reg_req <= {1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_req <= {1'b1, 1'b0, a, 8'h00};
        @(posedge core_clk);
        d = reg_rdata;
        reg_req <= {1'b0, 1'b0, ~a, 8'hFF};
    endtask
endmodule // bvm_host
`default_nettype wire

// >>> bvm_map.svh
// Purpose: register offsets, field positions and reset values of the battery monitor
// Assumes: 7-bit register address, 8-bit register data
// Notes:   included by the package and by the monitor modules
`ifndef BVM_MAP_SVH
`define BVM_MAP_SVH
`define BVM_ADDR_SRC_SEL      7'h11
`define BVM_ADDR_UNDER_TRIP   7'h12
`define BVM_ADDR_OVER_TRIP    7'h13
`define BVM_ADDR_HYST         7'h14
`define BVM_ADDR_BAT_UPPER    7'h15
`define BVM_ADDR_BAT_LOWER    7'h16
`define BVM_ADDR_SNS_UPPER    7'h17
`define BVM_ADDR_SNS_LOWER    7'h18
`define BVM_ADDR_SUPPLY_STAT  7'h1B
`define BVM_BIT_SRC_SEL       0
`define BVM_BIT_READ_FLAG     2
`define BVM_BIT_UNDER_STATE   4
`define BVM_BIT_OVER_STATE    5
`define BVM_RST_SRC_SEL       1'h0
`define BVM_RST_UNDER_TRIP    8'h00
`define BVM_RST_OVER_TRIP     8'hFF
`define BVM_RST_HYST          8'h00
`define BVM_RES_W             10
`define BVM_HYST_SHIFT        4
`endif

// >>> bvm_monitor.sv
// Purpose: two-channel battery voltage monitor with thresholds and hysteresis
// Assumes: register port driven by the serial interface logic on core_clk
// Notes:   results come from the converter as 10-bit codes of 20 V full scale
`include "bvm_map.svh"
`timescale 1ns/1ns
`default_nettype none
module bvm_monitor (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  normal_mode,
    input  wire bvm_pkg::bvm_results_t results,
    input  wire bvm_pkg::bvm_reg_req_t reg_req,
    input  wire logic [1:0]            shutdown_ctrl,
    output logic      [7:0]            reg_rdata,
    output logic                       under_voltage_irq,
    output logic                       over_voltage_irq,
    output logic                       load_shutdown
);
    bvm_pkg::bvm_state_t state_reg;
    bvm_pkg::bvm_state_t state_next;
    logic       event_source_select;
    logic [7:0] under_trip_code;
    logic [7:0] over_trip_code;
    logic [7:0] hyst_reg;
    logic       under_voltage_state;
    logic       over_voltage_state;
    logic       under_next;
    logic       over_next;
    logic       under_irq_reg;
    logic       over_irq_reg;
    logic [7:0] bat_up;
    logic [7:0] bat_lo;
    logic [7:0] sns_up;
    logic [7:0] sns_lo;
    wire        active = (state_reg == bvm_pkg::BVM_ST_ACTIVE);
    wire        wr = reg_req.wr;
    wire [6:0]  ad = reg_req.addr;
    wire [`BVM_RES_W-1:0] sel_val = event_source_select ? results.sns : results.bat;
    // 8-bit codes scale to 10 bits by a shift of two
    wire [11:0] u_trip = {2'h0, under_trip_code, 2'h0};
    wire [11:0] o_trip = {2'h0, over_trip_code, 2'h0};
    wire [11:0] u_off  = {4'h0, hyst_reg[3:0], 4'h0};
    wire [11:0] o_off  = {4'h0, hyst_reg[7:4], 4'h0};
    wire [11:0] u_rel  = u_trip + u_off;
    wire [11:0] o_rel  = (o_off > o_trip) ? 12'h000 : (o_trip - o_off);
    wire [11:0] val    = {2'h0, sel_val};
    wire        under_enter = !under_voltage_state && (val < u_trip);
    wire        over_enter  = !over_voltage_state && (val > o_trip);

    // mode tracker
    always_comb
    begin
        state_next = normal_mode ? bvm_pkg::BVM_ST_ACTIVE : bvm_pkg::BVM_ST_IDLE;
        case (state_reg)
            bvm_pkg::BVM_ST_IDLE:   state_next = normal_mode ? bvm_pkg::BVM_ST_ACTIVE : bvm_pkg::BVM_ST_IDLE;
            bvm_pkg::BVM_ST_ACTIVE: state_next = normal_mode ? bvm_pkg::BVM_ST_ACTIVE : bvm_pkg::BVM_ST_IDLE;
            default:                state_next = bvm_pkg::BVM_ST_IDLE;
        endcase
    end

    // hysteresis state; cleared when inactive
    always_comb
    begin
        under_next = under_voltage_state;
        over_next  = over_voltage_state;
        if (!active)
        begin
            under_next = 1'h0;
            over_next  = 1'h0;
        end
        else
        begin
            if (val < u_trip)
                under_next = 1'h1;
            else if (val > u_rel)
                under_next = 1'h0;
            if (val > o_trip)
                over_next = 1'h1;
            else if (val < o_rel)
                over_next = 1'h0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_reg           <= bvm_pkg::BVM_ST_IDLE;
            event_source_select <= `BVM_RST_SRC_SEL;
            under_trip_code     <= `BVM_RST_UNDER_TRIP;
            over_trip_code      <= `BVM_RST_OVER_TRIP;
            hyst_reg            <= `BVM_RST_HYST;
            under_voltage_state <= 1'h0;
            over_voltage_state  <= 1'h0;
            under_irq_reg       <= 1'h0;
            over_irq_reg        <= 1'h0;
        end
        else
        begin
            state_reg           <= state_next;
            under_voltage_state <= under_next;
            over_voltage_state  <= over_next;
            under_irq_reg       <= active && under_enter;
            over_irq_reg        <= active && over_enter;
            if (wr && ad == `BVM_ADDR_SRC_SEL)
                event_source_select <= reg_req.wdata[`BVM_BIT_SRC_SEL];
            if (wr && ad == `BVM_ADDR_UNDER_TRIP)
                under_trip_code <= reg_req.wdata;
            if (wr && ad == `BVM_ADDR_OVER_TRIP)
                over_trip_code <= reg_req.wdata;
            if (wr && ad == `BVM_ADDR_HYST)
                hyst_reg <= reg_req.wdata;
        end
    end

    assign under_voltage_irq = under_irq_reg;
    assign over_voltage_irq  = over_irq_reg;
    // optional load shut-off: bit0 on under, bit1 on over
    assign load_shutdown = (shutdown_ctrl[0] && under_voltage_state)
                         || (shutdown_ctrl[1] && over_voltage_state);

    wire rd = reg_req.rd;
    bvm_result_reg u_bat (
        .core_clk   (core_clk),
        .rst        (rst),
        .result     (results.bat),
        .rd_upper   (rd && ad == `BVM_ADDR_BAT_UPPER),
        .rd_lower   (rd && ad == `BVM_ADDR_BAT_LOWER),
        .upper_data (bat_up),
        .lower_data (bat_lo)
    );
    bvm_result_reg u_sns (
        .core_clk   (core_clk),
        .rst        (rst),
        .result     (results.sns),
        .rd_upper   (rd && ad == `BVM_ADDR_SNS_UPPER),
        .rd_lower   (rd && ad == `BVM_ADDR_SNS_LOWER),
        .upper_data (sns_up),
        .lower_data (sns_lo)
    );

    // read mux, unmapped reads zero
    wire [7:0] stat = {2'h0, over_voltage_state, under_voltage_state, 4'h0};
    always_comb
    begin
        if (ad == `BVM_ADDR_SRC_SEL)          reg_rdata = {7'h00, event_source_select};
        else if (ad == `BVM_ADDR_UNDER_TRIP)  reg_rdata = under_trip_code;
        else if (ad == `BVM_ADDR_OVER_TRIP)   reg_rdata = over_trip_code;
        else if (ad == `BVM_ADDR_HYST)        reg_rdata = hyst_reg;
        else if (ad == `BVM_ADDR_BAT_UPPER)   reg_rdata = bat_up;
        else if (ad == `BVM_ADDR_BAT_LOWER)   reg_rdata = bat_lo;
        else if (ad == `BVM_ADDR_SNS_UPPER)   reg_rdata = sns_up;
        else if (ad == `BVM_ADDR_SNS_LOWER)   reg_rdata = sns_lo;
        else if (ad == `BVM_ADDR_SUPPLY_STAT) reg_rdata = stat;
        else                                  reg_rdata = 8'h00;
    end

    a_idle_no_irq: assert property (@(posedge core_clk) disable iff (rst)
        !normal_mode |=> ##1 !under_voltage_irq && !over_voltage_irq)
        else $error("irq outside normal mode");
    a_under_irq_entry: assert property (@(posedge core_clk) disable iff (rst)
        under_voltage_irq |-> !$past(under_voltage_state) && under_voltage_state)
        else $error("under irq not on entry");
    a_over_irq_entry: assert property (@(posedge core_clk) disable iff (rst)
        over_voltage_irq |-> !$past(over_voltage_state) && over_voltage_state)
        else $error("over irq not on entry");
    a_over_hold_hyst: assert property (@(posedge core_clk) disable iff (rst)
        active && over_voltage_state && val >= o_rel |=> over_voltage_state)
        else $error("over released early");
    a_under_hold_hyst: assert property (@(posedge core_clk) disable iff (rst)
        active && under_voltage_state && val <= u_rel |=> under_voltage_state)
        else $error("under released early");
    a_under_trip_set: assert property (@(posedge core_clk) disable iff (rst)
        active && normal_mode && val < u_trip |=> under_voltage_state)
        else $error("under not set");
    a_over_trip_set: assert property (@(posedge core_clk) disable iff (rst)
        active && normal_mode && val > o_trip |=> over_voltage_state)
        else $error("over not set");
    a_status_bits: assert property (@(posedge core_clk) disable iff (rst)
        ad == `BVM_ADDR_SUPPLY_STAT |-> reg_rdata[5:4] == {over_voltage_state, under_voltage_state})
        else $error("status bits");
    a_under_irq_pulse: assert property (@(posedge core_clk) disable iff (rst)
        under_voltage_irq |=> !under_voltage_irq)
        else $error("under irq longer than one cycle");
    a_over_irq_pulse: assert property (@(posedge core_clk) disable iff (rst)
        over_voltage_irq |=> !over_voltage_irq)
        else $error("over irq longer than one cycle");
    a_under_irq_set: assert property (@(posedge core_clk) disable iff (rst)
        active && !under_voltage_state && val < u_trip |=> under_voltage_irq)
        else $error("under irq missing");
    a_over_irq_set: assert property (@(posedge core_clk) disable iff (rst)
        active && !over_voltage_state && val > o_trip |=> over_voltage_irq)
        else $error("over irq missing");
    a_under_release: assert property (@(posedge core_clk) disable iff (rst)
        active && under_voltage_state && val > u_rel |=> !under_voltage_state)
        else $error("under not released");
    a_over_release: assert property (@(posedge core_clk) disable iff (rst)
        active && over_voltage_state && val < o_rel |=> !over_voltage_state)
        else $error("over not released");
    a_idle_clears_state: assert property (@(posedge core_clk) disable iff (rst)
        !active |=> !under_voltage_state && !over_voltage_state)
        else $error("state kept while inactive");
    a_idle_no_shutdown: assert property (@(posedge core_clk) disable iff (rst)
        !active |=> !load_shutdown)
        else $error("shutdown while inactive");
    a_mode_enter: assert property (@(posedge core_clk) disable iff (rst)
        normal_mode |=> active)
        else $error("monitor not active in normal mode");
    a_mode_leave: assert property (@(posedge core_clk) disable iff (rst)
        !normal_mode |=> !active)
        else $error("monitor active outside normal mode");
    a_state_onehot: assert property (@(posedge core_clk) disable iff (rst)
        $onehot(state_reg))
        else $error("mode state not one-hot");
    a_select_write: assert property (@(posedge core_clk) disable iff (rst)
        wr && ad == `BVM_ADDR_SRC_SEL |=> event_source_select == $past(reg_req.wdata[`BVM_BIT_SRC_SEL]))
        else $error("source select not written");
    a_under_code_write: assert property (@(posedge core_clk) disable iff (rst)
        wr && ad == `BVM_ADDR_UNDER_TRIP |=> under_trip_code == $past(reg_req.wdata))
        else $error("under code not written");
    a_over_code_write: assert property (@(posedge core_clk) disable iff (rst)
        wr && ad == `BVM_ADDR_OVER_TRIP |=> over_trip_code == $past(reg_req.wdata))
        else $error("over code not written");
    a_hyst_write: assert property (@(posedge core_clk) disable iff (rst)
        wr && ad == `BVM_ADDR_HYST |=> hyst_reg == $past(reg_req.wdata))
        else $error("hysteresis not written");
endmodule // bvm_monitor
`default_nettype wire

// >>> bvm_pkg.sv
// Purpose: shared types of the battery monitor
// Assumes: bvm_map.svh gives the widths
// Notes:   types only, no constants beyond those of the header
`include "bvm_map.svh"
package bvm_pkg;
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } bvm_reg_req_t;
    typedef struct packed {
        logic [`BVM_RES_W-1:0] bat;
        logic [`BVM_RES_W-1:0] sns;
    } bvm_results_t;
    typedef enum logic [1:0] {
        BVM_ST_IDLE   = 2'h1,
        BVM_ST_ACTIVE = 2'h2
    } bvm_state_t;
endpackage

// >>> bvm_result_reg.sv
// Purpose: one channel's split result with its upper-read flag
// Assumes: result input comes from logic on core_clk
// Notes:   result is frozen from upper read until lower read
`include "bvm_map.svh"
`timescale 1ns/1ns
`default_nettype none
module bvm_result_reg (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic [`BVM_RES_W-1:0] result,
    input  wire logic                  rd_upper,
    input  wire logic                  rd_lower,
    output logic      [7:0]            upper_data,
    output logic      [7:0]            lower_data
);
    logic [`BVM_RES_W-1:0] hold_reg;
    logic                  flag_reg;
    logic                  flag_next;
    logic                  hold_load;
    // flag set on upper read, cleared by lower read; set wins
    assign flag_next = rd_upper ? 1'h1 : (rd_lower ? 1'h0 : flag_reg);
    // an upper read freezes the value it showed, so the lower read pairs with it
    assign hold_load = (!flag_reg && !rd_upper) || rd_lower;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            hold_reg <= '0;
            flag_reg <= 1'h0;
        end
        else
        begin
            if (hold_load)
                hold_reg <= result;
            flag_reg <= flag_next;
        end
    end
    assign upper_data = hold_reg[9:2];
    assign lower_data = {5'h00, flag_reg, hold_reg[1:0]};
    a_flag_set_read: assert property (@(posedge core_clk) disable iff (rst)
        rd_upper |=> flag_reg)
        else $error("read flag not set after upper read");
    a_flag_clear_read: assert property (@(posedge core_clk) disable iff (rst)
        rd_lower && !rd_upper |=> !flag_reg)
        else $error("read flag not cleared after lower read");
    a_hold_frozen: assert property (@(posedge core_clk) disable iff (rst)
        rd_upper || (flag_reg && !rd_lower) |=> $stable(hold_reg))
        else $error("result changed between upper and lower read");
endmodule // bvm_result_reg
`default_nettype wire
